// ---- rtl/scad_addr_split.sv ----
`timescale 1ns/1ns
// Reassembles the two address halves into bank and A12..A0.
module scad_addr_split (
    input wire logic [7:0] first_in,
    input wire logic [7:0] second_in,
    output logic [2:0] bank_out,
    output logic [12:0] addr_out
);
    always_comb begin
        bank_out = first_in[7:5];
        addr_out[12:8] = first_in[4:0];
        addr_out[6] = second_in[7];
        addr_out[5] = second_in[6];
        addr_out[1] = second_in[5];
        addr_out[2] = second_in[4];
        addr_out[3] = second_in[3];
        addr_out[0] = second_in[2];
        addr_out[7] = second_in[1];
        addr_out[4] = second_in[0];
    end
endmodule : scad_addr_split

// ---- rtl/scad_bank_state.sv ----
`timescale 1ns/1ns
// One bank's open-row flag with its auto-precharge countdown.
module scad_bank_state (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic act_in,
    input wire logic pre_in,
    input wire logic ap_in,
    output logic open_out
);
    logic [3:0] ap_cnt_r;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            open_out <= 1'b0;
        end else if (ce_in) begin
            if (act_in) begin
                open_out <= 1'b1;
            end else if (pre_in || ap_cnt_r == 4'h1) begin
                open_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ap_cnt_r <= 4'h0;
        end else if (ce_in) begin
            if (ap_in) begin
                ap_cnt_r <= scad_pkg::SCAD_AP_CNT;
            end else if (pre_in || act_in) begin
                ap_cnt_r <= 4'h0;
            end else if (ap_cnt_r != 4'h0) begin
                ap_cnt_r <= ap_cnt_r - 4'h1;
            end
        end
    end
endmodule : scad_bank_state

// ---- rtl/scad_pkg.sv ----
package scad_pkg;
    // Command codes decoded from the strobes.
    typedef enum logic [3:0] {
        SCAD_CMD_NONE = 4'h0,
        SCAD_CMD_ACT = 4'h1,
        SCAD_CMD_RD = 4'h2,
        SCAD_CMD_WR = 4'h3,
        SCAD_CMD_PRE = 4'h4,
        SCAD_CMD_MRS = 4'h5,
        SCAD_CMD_AREF = 4'h6,
        SCAD_CMD_SREF = 4'h7
    } scad_cmd_e;

    // Power states: active and the two low power states.
    typedef enum logic [2:0] {
        SCAD_PWR_ACTIVE = 3'h1,
        SCAD_PWR_DOWN = 3'h2,
        SCAD_PWR_SELF = 3'h4
    } scad_pwr_e;

    localparam int SCAD_BANKS = 8;
    localparam int SCAD_OP_W = 13;
    localparam logic [2:0] SCAD_MR_BASE = 3'h0;
    localparam logic [2:0] SCAD_MR_EXT1 = 3'h1;
    localparam logic [2:0] SCAD_MR_EXT2 = 3'h2;
    localparam logic [2:0] SCAD_MR_EXT3 = 3'h3;
    localparam logic [12:0] SCAD_MR_RST = 13'h0000;
    // Field positions in the third extended mode register.
    localparam int SCAD_LP_TERM_BIT = 5;
    localparam int SCAD_INFO_SEL_BIT = 6;
    // Position of A8 in the captured address word.
    localparam int SCAD_AP_BIT = 8;
    // Cycles an auto-precharge access keeps the row open before it closes.
    localparam int SCAD_AP_CYCLES = 8;
    localparam logic [3:0] SCAD_AP_CNT = 4'(SCAD_AP_CYCLES);
endpackage : scad_pkg

// ---- rtl/scad_top.sv ----
`timescale 1ns/1ns
// Function
// - MRS bank 011 loads third extended register
// - Implemented optional fields act when set
// - Info select picks parity or vendor id
// - Address arrives in two consecutive halves
// - Fixed pin order for both halves
// - Commands take two clocks, NOP one
// - Row, column, bank fields; A8 auto precharge
// - Decode read and write
// - Decode activate and precharge
// - Precharge one bank or all on A8
// - MRS op-code to register chosen by bank
// - Refresh: auto or self refresh entry
// - Clock enable edges enter and exit low power
// - Deselect excludes terminator disable pattern
// - Terminator disable not in low power
// - Data mask high inhibits element write
// - Chip select high blocks new commands
// - NOP registers nothing, work continues
module scad_top (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic cs_n_in,
    input wire logic ras_n_in,
    input wire logic cas_n_in,
    input wire logic we_n_in,
    input wire logic cke_n_in,
    input wire logic [7:0] addr_in,
    input wire logic data_mask_input_in,
    input wire logic wr_data_valid_in,
    output logic [3:0] cmd_out,
    output logic cmd_valid_out,
    output logic [2:0] bank_out,
    output logic [11:0] row_out,
    output logic [8:0] col_out,
    output logic auto_pre_out,
    output logic pre_all_out,
    output logic [12:0] mode_reg_out,
    output logic [12:0] ext_mode_reg1_out,
    output logic [12:0] ext_mode_reg2_out,
    output logic [12:0] third_extended_mode_reg_out,
    output logic low_power_termination_out,
    output logic info_is_vendor_out,
    output logic [7:0] bank_open_out,
    output logic [2:0] pwr_state_out,
    output logic term_disable_out,
    output logic wr_elem_en_out
);
    // ----------------------------------------------------------------
    // Command capture
    // ----------------------------------------------------------------
    logic second_r;
    logic [3:0] pend_cmd_r;
    logic [7:0] first_half_r;
    logic cke_prev_r;
    logic [2:0] bank_w;
    logic [12:0] addr_w;
    scad_pkg::scad_cmd_e dec_cmd;
    scad_pkg::scad_pwr_e pwr_r;
    logic sel;

    // The previous-cycle clock enable is remembered so that its edges can be seen.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cke_prev_r <= 1'b0;
        end else if (ce_in) begin
            cke_prev_r <= cke_n_in;
        end
    end

    assign sel = !cs_n_in;

    always_comb begin
        dec_cmd = scad_pkg::SCAD_CMD_NONE;
        if (sel && !cke_prev_r && !cke_n_in) begin
            case ({ras_n_in, cas_n_in, we_n_in})
                3'b011: dec_cmd = scad_pkg::SCAD_CMD_ACT;
                3'b010: dec_cmd = scad_pkg::SCAD_CMD_PRE;
                3'b101: dec_cmd = scad_pkg::SCAD_CMD_RD;
                3'b100: dec_cmd = scad_pkg::SCAD_CMD_WR;
                3'b000: dec_cmd = scad_pkg::SCAD_CMD_MRS;
                3'b001: dec_cmd = scad_pkg::SCAD_CMD_AREF;
                default: dec_cmd = scad_pkg::SCAD_CMD_NONE;
            endcase
        end else if (sel && !cke_prev_r && {ras_n_in, cas_n_in, we_n_in} == 3'b001) begin
            dec_cmd = scad_pkg::SCAD_CMD_SREF;
        end
    end

    // A two-cycle command owns the next edge; nothing is decoded there.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            second_r <= 1'b0;
            pend_cmd_r <= 4'h0;
            first_half_r <= 8'h00;
        end else if (ce_in) begin
            if (second_r) begin
                second_r <= 1'b0;
            end else if (dec_cmd != scad_pkg::SCAD_CMD_NONE
                && pwr_r == scad_pkg::SCAD_PWR_ACTIVE) begin
                second_r <= 1'b1;
                pend_cmd_r <= dec_cmd;
                first_half_r <= addr_in;
            end
        end
    end

    scad_addr_split u_split (
        .first_in(first_half_r),
        .second_in(addr_in),
        .bank_out(bank_w),
        .addr_out(addr_w)
    );

    // ----------------------------------------------------------------
    // Completed command outputs
    // ----------------------------------------------------------------
    logic done;
    assign done = second_r;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cmd_out <= 4'h0;
            cmd_valid_out <= 1'b0;
            bank_out <= 3'h0;
            row_out <= 12'h000;
            col_out <= 9'h000;
            auto_pre_out <= 1'b0;
            pre_all_out <= 1'b0;
        end else if (ce_in) begin
            cmd_valid_out <= done;
            if (done) begin
                cmd_out <= pend_cmd_r;
                bank_out <= bank_w;
                row_out <= addr_w[11:0];
                col_out <= {addr_w[9], addr_w[7:0]};
                auto_pre_out <= addr_w[scad_pkg::SCAD_AP_BIT];
                pre_all_out <= addr_w[scad_pkg::SCAD_AP_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // Mode registers
    // ----------------------------------------------------------------
    logic mrs_done;
    assign mrs_done = done && pend_cmd_r == scad_pkg::SCAD_CMD_MRS;

    // Reserved bank codes are dropped, so a stray MRS cannot corrupt a register.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mode_reg_out <= scad_pkg::SCAD_MR_RST;
            ext_mode_reg1_out <= scad_pkg::SCAD_MR_RST;
            ext_mode_reg2_out <= scad_pkg::SCAD_MR_RST;
            third_extended_mode_reg_out <= scad_pkg::SCAD_MR_RST;
        end else if (ce_in && mrs_done) begin
            case (bank_w)
                scad_pkg::SCAD_MR_BASE: mode_reg_out <= addr_w;
                scad_pkg::SCAD_MR_EXT1: ext_mode_reg1_out <= addr_w;
                scad_pkg::SCAD_MR_EXT2: ext_mode_reg2_out <= addr_w;
                scad_pkg::SCAD_MR_EXT3: third_extended_mode_reg_out <= addr_w;
                default: ;
            endcase
        end
    end

    // Optional fields are mirrored straight from the register.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            low_power_termination_out <= 1'b0;
            info_is_vendor_out <= 1'b0;
        end else if (ce_in) begin
            low_power_termination_out <=
                third_extended_mode_reg_out[scad_pkg::SCAD_LP_TERM_BIT];
            info_is_vendor_out <= third_extended_mode_reg_out[scad_pkg::SCAD_INFO_SEL_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Bank state
    // ----------------------------------------------------------------
    logic [7:0] bank_open_w;
    genvar gi;
    generate
        for (gi = 0; gi < scad_pkg::SCAD_BANKS; gi++) begin : g_bank
            logic hit;
            assign hit = done && bank_w == 3'(gi);
            scad_bank_state u_bank (
                .clk_in(clk_in),
                .sys_rst_in(sys_rst_in),
                .ce_in(ce_in),
                .act_in(hit && pend_cmd_r == scad_pkg::SCAD_CMD_ACT),
                .pre_in(done && pend_cmd_r == scad_pkg::SCAD_CMD_PRE
                    && (hit || addr_w[scad_pkg::SCAD_AP_BIT])),
                .ap_in(hit && addr_w[scad_pkg::SCAD_AP_BIT]
                    && (pend_cmd_r == scad_pkg::SCAD_CMD_RD
                    || pend_cmd_r == scad_pkg::SCAD_CMD_WR)),
                .open_out(bank_open_w[gi])
            );
        end
    endgenerate

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bank_open_out <= 8'h00;
        end else if (ce_in) begin
            bank_open_out <= bank_open_w;
        end
    end

    // ----------------------------------------------------------------
    // Power state, terminator disable and write mask
    // ----------------------------------------------------------------
    logic nop_or_desel;
    assign nop_or_desel = cs_n_in ? !(ras_n_in && !cas_n_in && we_n_in)
        : (ras_n_in && cas_n_in && we_n_in);

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pwr_r <= scad_pkg::SCAD_PWR_ACTIVE;
        end else if (ce_in) begin
            case (pwr_r)
                scad_pkg::SCAD_PWR_ACTIVE: begin
                    if (dec_cmd == scad_pkg::SCAD_CMD_SREF && !second_r) begin
                        pwr_r <= scad_pkg::SCAD_PWR_SELF;
                    end else if (!cke_prev_r && cke_n_in && nop_or_desel && !second_r) begin
                        pwr_r <= scad_pkg::SCAD_PWR_DOWN;
                    end
                end
                scad_pkg::SCAD_PWR_DOWN, scad_pkg::SCAD_PWR_SELF: begin
                    if (cke_prev_r && !cke_n_in && nop_or_desel) begin
                        pwr_r <= scad_pkg::SCAD_PWR_ACTIVE;
                    end
                end
                default: pwr_r <= scad_pkg::SCAD_PWR_ACTIVE;
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pwr_state_out <= scad_pkg::SCAD_PWR_ACTIVE;
            term_disable_out <= 1'b0;
            wr_elem_en_out <= 1'b0;
        end else if (ce_in) begin
            pwr_state_out <= pwr_r;
            // Ignored in low power, where the pattern has no defined meaning.
            term_disable_out <= cs_n_in && ras_n_in && !cas_n_in && we_n_in
                && !cke_prev_r && !cke_n_in && !second_r
                && pwr_r == scad_pkg::SCAD_PWR_ACTIVE;
            wr_elem_en_out <= wr_data_valid_in && !data_mask_input_in;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    second_cycle_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        ce_in && dec_cmd != scad_pkg::SCAD_CMD_NONE && !second_r
        && pwr_r == scad_pkg::SCAD_PWR_ACTIVE |=> second_r)
        else $error("two-cycle command missed its second half");
    valid_pulse_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        ce_in && second_r |=> cmd_valid_out && $past(pend_cmd_r) == cmd_out)
        else $error("command not reported after second half");
    desel_block_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        cs_n_in |-> dec_cmd == scad_pkg::SCAD_CMD_NONE)
        else $error("deselected cycle decoded a command");
    third_load_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        ce_in && mrs_done && bank_w == 3'h3
        |=> third_extended_mode_reg_out == $past(addr_w))
        else $error("third extended register not loaded");
    base_keep_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !(ce_in && mrs_done && bank_w == 3'h0) |=> $stable(mode_reg_out))
        else $error("base mode register changed without MRS");
    low_term_map_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        ce_in |=> low_power_termination_out == $past(third_extended_mode_reg_out[5]))
        else $error("low power termination mirror wrong");
    info_map_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        ce_in |=> info_is_vendor_out == $past(third_extended_mode_reg_out[6]))
        else $error("info select mirror wrong");
    mask_write_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        ce_in && data_mask_input_in |=> !wr_elem_en_out)
        else $error("masked element was enabled");
    act_open_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        ce_in && done && pend_cmd_r == scad_pkg::SCAD_CMD_ACT
        |=> bank_open_w[$past(bank_w)])
        else $error("activate did not open bank");
    col_map_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        ce_in && done |=> col_out == {$past(addr_w[9]), $past(addr_w[7:0])})
        else $error("column address mapping wrong");
    tdis_low_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        term_disable_out |-> $past(pwr_r) == scad_pkg::SCAD_PWR_ACTIVE)
        else $error("terminator disable in low power");
    act_cov: cover property (@(posedge clk_in) cmd_valid_out && cmd_out == 4'h1);
    mrs_cov: cover property (@(posedge clk_in) ce_in && mrs_done && bank_w == 3'h3);
    sref_cov: cover property (@(posedge clk_in) pwr_r == scad_pkg::SCAD_PWR_SELF);
    pd_cov: cover property (@(posedge clk_in) pwr_r == scad_pkg::SCAD_PWR_DOWN);
endmodule : scad_top

// ---- tb/scad_ctrl_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// Controller model driving strobes and address
// ----------------------------------------
module scad_ctrl_model #(
    parameter int ACT_GAP = 4
) (
    input wire logic clk_in,
    output logic cs_n_out,
    output logic ras_n_out,
    output logic cas_n_out,
    output logic we_n_out,
    output logic cke_n_out,
    output logic [7:0] addr_out
);
    logic act_last = 1'b0;

    initial begin
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hF;
        cke_n_out = 1'b0;
        addr_out = 8'h00;
    end

    // Undriven address cycles flip every bit so a held value never looks valid.
    task automatic pin(input logic [3:0] s, input logic ck);
        @(negedge clk_in);
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = s;
        cke_n_out = ck;
        addr_out = ~addr_out;
    endtask : pin

    task automatic issue(input logic [3:0] s1, input logic [3:0] s2, input logic [2:0] ba,
                         input logic [12:0] a);
        if (act_last) begin
            repeat (ACT_GAP) @(negedge clk_in);
        end
        act_last = (s1 == 4'h3);
        @(negedge clk_in);
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = s1;
        addr_out = {ba, a[12:8]};
        @(negedge clk_in);
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = s2;
        addr_out = {a[6], a[5], a[1], a[2], a[3], a[0], a[7], a[4]};
        @(negedge clk_in);
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hF;
        addr_out = ~addr_out;
    endtask : issue
endmodule : scad_ctrl_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
module testbench;
    localparam logic [3:0] S_ACT = 4'h3;
    localparam logic [3:0] S_RD = 4'h5;
    localparam logic [3:0] S_WR = 4'h4;
    localparam logic [3:0] S_PRE = 4'h2;
    localparam logic [3:0] S_MRS = 4'h0;
    localparam logic [3:0] S_REF = 4'h1;
    localparam logic [3:0] S_NOP = 4'h7;
    localparam logic [3:0] S_DES = 4'hF;
    localparam logic [3:0] S_TDIS = 4'hD;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic wmask = 1'b0;
    logic ce = 1'b1;
    logic wdv = 1'b0;
    logic cs_n, ras_n, cas_n, we_n, cke_n, cmd_v, ap, pall, lpt, info, tdis, wen;
    logic [7:0] addr, bopen;
    logic [3:0] cmd;
    logic [2:0] bank, pwr;
    logic [11:0] row;
    logic [8:0] col;
    logic [12:0] mr0, mr1, mr2, mr3;
    logic [12:0] mrv [4] = '{13'h1ABC, 13'h0F0F, 13'h1234, 13'h0060};
    int fails = 0;
    int checks = 0;

    always #25 clk_in = ~clk_in;

    scad_ctrl_model ctrl_u (.clk_in(clk_in), .cs_n_out(cs_n), .ras_n_out(ras_n),
        .cas_n_out(cas_n), .we_n_out(we_n), .cke_n_out(cke_n), .addr_out(addr));

    scad_top dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce), .cs_n_in(cs_n),
        .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .cke_n_in(cke_n), .addr_in(addr),
        .data_mask_input_in(wmask), .wr_data_valid_in(wdv), .cmd_out(cmd), .cmd_valid_out(cmd_v),
        .bank_out(bank), .row_out(row), .col_out(col), .auto_pre_out(ap), .pre_all_out(pall),
        .mode_reg_out(mr0), .ext_mode_reg1_out(mr1), .ext_mode_reg2_out(mr2),
        .third_extended_mode_reg_out(mr3), .low_power_termination_out(lpt),
        .info_is_vendor_out(info), .bank_open_out(bopen), .pwr_state_out(pwr),
        .term_disable_out(tdis), .wr_elem_en_out(wen));

    // ----------------------------------------
    // Shared checks and sequences
    // ----------------------------------------
    task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic run(input logic [3:0] s, input logic [2:0] ba, input logic [12:0] a,
                       input logic [3:0] c);
        ctrl_u.issue(s, S_DES, ba, a);
        chk("cmd_valid", 13'h1, 13'(cmd_v));
        chk("cmd", 13'(c), 13'(cmd));
    endtask : run

    // The second edge lets the registered power state catch up.
    task automatic lp(input logic [3:0] s, input logic ck, input logic [2:0] e);
        ctrl_u.pin(s, ck);
        ctrl_u.pin(S_DES, ck);
        @(negedge clk_in);
        chk("pwr_state", 13'(e), 13'(pwr));
    endtask : lp

    task automatic test_done;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    initial begin
        #(50 * 3000);
        fails++;
        $display("watchdog expired");
        test_done();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk_in);
        @(negedge clk_in);
        sys_rst_in = 1'b0;
        chk("pwr_state", 13'h1, 13'(pwr));
        chk("third_reg", 13'h0, mr3);
        chk("bank_open", 13'h0, 13'(bopen));
        $display("test reset done");
        run(S_ACT, 3'h5, 13'h1A5C, scad_pkg::SCAD_CMD_ACT);
        chk("bank", 13'h5, 13'(bank));
        chk("row", 13'h0A5C, 13'(row));
        @(negedge clk_in);
        chk("cmd_valid", 13'h0, 13'(cmd_v));
        chk("bank_open", 13'h20, 13'(bopen));
        run(S_RD, 3'h5, 13'h02B7, scad_pkg::SCAD_CMD_RD);
        chk("col", 13'h01B7, 13'(col));
        chk("auto_pre", 13'h0, 13'(ap));
        run(S_WR, 3'h5, 13'h0100, scad_pkg::SCAD_CMD_WR);
        chk("col", 13'h0, 13'(col));
        chk("auto_pre", 13'h1, 13'(ap));
        chk("bank_open", 13'h20, 13'(bopen));
        repeat (scad_pkg::SCAD_AP_CYCLES + 3) @(negedge clk_in);
        chk("bank_open", 13'h0, 13'(bopen));
        wdv = 1'b1;
        @(negedge clk_in);
        wmask = 1'b1;
        chk("wr_elem_en", 13'h1, 13'(wen));
        @(negedge clk_in);
        wdv = 1'b0;
        chk("wr_elem_en", 13'h0, 13'(wen));
        wmask = 1'b0;
        $display("test access done");
        run(S_ACT, 3'h2, 13'h0001, scad_pkg::SCAD_CMD_ACT);
        run(S_ACT, 3'h3, 13'h0002, scad_pkg::SCAD_CMD_ACT);
        run(S_PRE, 3'h2, 13'h0000, scad_pkg::SCAD_CMD_PRE);
        chk("pre_all", 13'h0, 13'(pall));
        @(negedge clk_in);
        chk("bank_open", 13'h08, 13'(bopen));
        run(S_PRE, 3'h6, 13'h0100, scad_pkg::SCAD_CMD_PRE);
        chk("pre_all", 13'h1, 13'(pall));
        @(negedge clk_in);
        chk("bank_open", 13'h0, 13'(bopen));
        $display("test precharge done");
        for (int i = 0; i < 4; i++) run(S_MRS, 3'(i), mrv[i], scad_pkg::SCAD_CMD_MRS);
        ctrl_u.issue(S_MRS, S_DES, 3'h4, 13'h1FFF);
        chk("mode_reg", mrv[0], mr0);
        chk("ext_reg1", mrv[1], mr1);
        chk("ext_reg2", mrv[2], mr2);
        chk("third_reg", mrv[3], mr3);
        chk("low_power_term", 13'h1, 13'(lpt));
        chk("info_vendor", 13'h1, 13'(info));
        run(S_MRS, 3'h3, 13'h0040, scad_pkg::SCAD_CMD_MRS);
        @(negedge clk_in);
        chk("third_reg", 13'h0040, mr3);
        chk("low_power_term", 13'h0, 13'(lpt));
        chk("ext_reg2", mrv[2], mr2);
        $display("test mode done");
        run(S_REF, 3'h0, 13'h0000, scad_pkg::SCAD_CMD_AREF);
        ctrl_u.pin(S_TDIS, 1'b0);
        ctrl_u.pin(S_DES, 1'b0);
        chk("term_disable", 13'h1, 13'(tdis));
        @(negedge clk_in);
        chk("term_disable", 13'h0, 13'(tdis));
        ctrl_u.issue(4'hB, S_DES, 3'h1, 13'h0001);
        chk("cmd_valid", 13'h0, 13'(cmd_v));
        chk("bank_open", 13'h0, 13'(bopen));
        ctrl_u.issue(S_ACT, S_RD, 3'h1, 13'h0001);
        chk("cmd", 13'(scad_pkg::SCAD_CMD_ACT), 13'(cmd));
        @(negedge clk_in);
        chk("cmd_valid", 13'h0, 13'(cmd_v));
        chk("bank_open", 13'h02, 13'(bopen));
        // A command given while the clock enable is low must leave no trace.
        ce = 1'b0;
        ctrl_u.issue(S_ACT, S_DES, 3'h4, 13'h0001);
        chk("cmd_valid", 13'h0, 13'(cmd_v));
        chk("bank_open", 13'h02, 13'(bopen));
        ce = 1'b1;
        $display("test decode done");
        lp(S_NOP, 1'b1, 3'h2);
        lp(S_DES, 1'b0, 3'h1);
        lp(S_REF, 1'b1, 3'h4);
        lp(S_DES, 1'b0, 3'h1);
        $display("test power done");
        test_done();
    end
endmodule : testbench
